/* File: rtl/hrx_pkg.sv */
`default_nettype none
package hrx_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] CFG_OFF             = 12'h000;
  localparam logic [11:0] CTRL_OFF            = 12'h004;
  localparam logic [11:0] STAT_OFF            = 12'h008;
  localparam int unsigned CTRL_REACTIVATE_BIT = 0;
  localparam int unsigned CFG_W               = 24;
  localparam logic [23:0] CFG_RESET           = 24'h000000;

  // ==========================================================================
  // Bit level constants
  localparam int unsigned MSG_BITS_W       = 15;
  localparam logic [14:0] FCS_BITS         = 15'h0010;
  localparam logic [14:0] MIN_PAYLOAD_BITS = 15'h0008;
  localparam logic [14:0] MIN_MSG_BITS     = FCS_BITS + MIN_PAYLOAD_BITS;
  localparam logic [7:0]  FLAG_PATTERN     = 8'h7E;
  localparam logic [7:0]  ABORT_PATTERN    = 8'h7F;
  localparam logic [4:0]  STUFF_RUN        = 5'h1F;
  localparam logic [2:0]  FLAG_LAG_BITS    = 3'h6;
  localparam logic [11:0] MAX_LEN_BASE     = 12'h100;
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'h8408;
  localparam logic [15:0] CRC_GOOD         = 16'hF0B8;

  // ==========================================================================
  // SS7 error rate counting
  localparam int unsigned SU_CNT_W   = 8;
  localparam int unsigned OCT_ERR_W  = 4;
  localparam int unsigned GOOD_RUN_W = 8;

  // ==========================================================================
  // Descriptor field values
  localparam logic OWNER_HOST = 1'b1;
  localparam logic DIR_RX     = 1'b0;
  localparam logic DIR_TX     = 1'b1;

  typedef enum logic [3:0] {
    no_error_code               = 4'h0,
    frame_loss_code             = 4'h1,
    crc_mismatch_code           = 4'h2,
    misalign_code               = 4'h3,
    abort_seen_code             = 4'h4,
    overlength_code             = 4'h5,
    underlength_code            = 4'h6,
    signal_unit_error_rate_code = 4'h7,
    owner_error_code            = 4'h8
  } hrx_code_e;

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b01,
    ST_FRAME = 2'b10
  } hrx_rx_e;

  typedef enum logic [2:0] {
    TX_ACTIVE = 3'b001,
    TX_REPORT = 3'b010,
    TX_DEACT  = 3'b100
  } hrx_tx_e;

  typedef struct packed {
    logic [7:0] signal_unit_error_threshold;
    logic [4:0] rsvd;
    logic       ss7_mode;
    logic       tx_transparent;
    logic       rx_transparent;
    logic [1:0] max_length_select;
    logic       signal_unit_error_irq_mask;
    logic       idle_class_irq_mask;
    logic       message_error_irq_mask;
    logic       rx_status_writeback_inhibit;
    logic       frame_loss_abort_select;
    logic       frame_loss_irq_mask;
  } hrx_cfg_s;

  typedef struct packed {
    logic [11:0] rsvd;
    hrx_code_e   last_code;
    logic [7:0]  su_cnt;
    logic [4:0]  rsvd2;
    logic        frame_loss;
    logic        tx_active;
    logic        rx_in_frame;
  } hrx_sreg_s;

  typedef struct packed {
    logic      valid;
    logic      dir;
    hrx_code_e code;
  } hrx_irq_s;

  typedef struct packed {
    logic      valid;
    logic      owner;
    hrx_code_e code;
  } hrx_stat_s;

endpackage
`default_nettype wire

/* File: rtl/hrx_crc16.sv */
`default_nettype none
module hrx_crc16 (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Bit stream
  input  wire logic clear,
  input  wire logic bit_en,
  input  wire logic bit_in,
  // Result
  output logic      good
);

  typedef struct packed {
    logic [15:0] crc;
  } hrx_crc_s;

  hrx_crc_s q;
  hrx_crc_s next_q;
  logic     fb;

  // ==========================================================================
  // LSB first update, residue compare over data plus FCS
  always_comb begin
    next_q = q;
    fb     = q.crc[0] ^ bit_in;
    if (clear) begin
      next_q.crc = hrx_pkg::CRC_INIT;
    end else if (bit_en) begin
      next_q.crc = {1'b0, q.crc[15:1]} ^ (fb ? hrx_pkg::CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.crc <= hrx_pkg::CRC_INIT;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign good = (q.crc == hrx_pkg::CRC_GOOD);

endmodule
`default_nettype wire

/* File: rtl/hrx_channel.sv */
// The register addresses and register access over APB were left to the implementer.
`default_nettype none
module hrx_channel #(
  parameter int unsigned MSG_W = hrx_pkg::MSG_BITS_W
) (
  // APB slave
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hrx_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Serial link from framer
  input  wire logic                        link_clk,
  input  wire logic                        link_rxd,
  input  wire logic                        link_frame_loss,
  // Receive DMA side
  input  wire logic                        desc_device_owned,
  output logic                             mem_byte_valid,
  output logic [7:0]                       mem_byte,
  output logic                             next_desc_fetch,
  output var hrx_pkg::hrx_stat_s           status_desc,
  output var hrx_pkg::hrx_irq_s            irq_desc,
  // Transparent transmit side
  input  wire logic                        tx_fifo_empty,
  input  wire logic                        tx_next_owned,
  output logic                             tx_desc_fetch,
  output logic                             tx_idle_send,
  output logic                             tx_active
);

  typedef struct packed {
    logic [2:0]                       clk_s;
    logic [1:0]                       rxd_s;
    logic [1:0]                       los_s;
    logic                             los_q;
    logic                             los_pend;
    hrx_pkg::hrx_cfg_s                cfg;
    hrx_pkg::hrx_rx_e                 rx_st;
    hrx_pkg::hrx_tx_e                 tx_st;
    logic [7:0]                       raw;
    logic [5:0]                       dly;
    logic [2:0]                       dly_cnt;
    logic [7:0]                       asm_byte;
    logic [MSG_W-1:0]                 msg_bits;
    logic [hrx_pkg::SU_CNT_W-1:0]     su_cnt;
    logic [hrx_pkg::OCT_ERR_W-1:0]    oct_errs;
    logic [hrx_pkg::GOOD_RUN_W-1:0]   good_run;
    logic                             su_pend;
    logic                             mem_valid;
    logic [7:0]                       mem_data;
    logic                             next_fetch;
    logic                             tx_fetch;
    hrx_pkg::hrx_stat_s               stat;
    hrx_pkg::hrx_irq_s                irq;
    hrx_pkg::hrx_code_e               last_code;
    logic [31:0]                      rdata;
  } hrx_state_s;

  hrx_state_s         q;
  hrx_state_s         next_q;
  hrx_pkg::hrx_sreg_s sreg;
  hrx_pkg::hrx_code_e ev_code;
  logic               bit_evt;
  logic               los_rise;
  logic               svc_los;
  logic               in_msg;
  logic [7:0]         win;
  logic               take;
  logic               obit;
  logic               end_msg;
  logic               ev_irq;
  logic               ev_ret;
  logic               ss7_inc;
  logic               ss7_oct;
  logic               ss7_good;
  logic               su_hit;
  logic               crc_clr;
  logic               crc_good;
  logic [11:0]        lim;
  logic               in_ss7;
  logic               apb_setup;
  logic               apb_wr;
  logic               hit_cfg;
  logic               hit_ctrl;
  logic               hit_stat;

  // ==========================================================================
  // Bus decode
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && ce;
  assign hit_cfg   = (paddr == hrx_pkg::CFG_OFF);
  assign hit_ctrl  = (paddr == hrx_pkg::CTRL_OFF);
  assign hit_stat  = (paddr == hrx_pkg::STAT_OFF);
  assign pready    = ce;
  assign pslverr   = psel && penable && !(hit_cfg || hit_ctrl || hit_stat);

  assign bit_evt  = q.clk_s[1] && !q.clk_s[2];
  assign los_rise = q.los_s[1] && !q.los_q;
  assign svc_los  = q.los_pend && !bit_evt;
  assign in_msg   = (q.rx_st == hrx_pkg::ST_FRAME) && (q.msg_bits != '0);
  assign win      = {q.raw[6:0], q.rxd_s[1]};
  assign lim      = hrx_pkg::MAX_LEN_BASE << q.cfg.max_length_select;
  assign in_ss7   = q.cfg.ss7_mode && !q.cfg.rx_transparent;

  always_comb begin
    sreg             = '0;
    sreg.last_code   = q.last_code;
    sreg.su_cnt      = q.su_cnt;
    sreg.frame_loss  = q.los_s[1];
    sreg.tx_active   = (q.tx_st != hrx_pkg::TX_DEACT);
    sreg.rx_in_frame = (q.rx_st == hrx_pkg::ST_FRAME);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_q            = q;
    take              = 1'b0;
    obit              = 1'b0;
    end_msg           = 1'b0;
    ev_irq            = 1'b0;
    ev_ret            = 1'b0;
    ev_code           = hrx_pkg::no_error_code;
    ss7_inc           = 1'b0;
    ss7_oct           = 1'b0;
    ss7_good          = 1'b0;
    su_hit            = 1'b0;
    crc_clr           = 1'b0;
    next_q.clk_s      = {q.clk_s[1:0], link_clk};
    next_q.rxd_s      = {q.rxd_s[0], link_rxd};
    next_q.los_s      = {q.los_s[0], link_frame_loss};
    next_q.los_q      = q.los_s[1];
    next_q.mem_valid  = 1'b0;
    next_q.next_fetch = 1'b0;
    next_q.tx_fetch   = 1'b0;
    next_q.stat.valid = 1'b0;
    next_q.irq.valid  = 1'b0;

    // Serial bit processing
    if (bit_evt) begin
      next_q.raw = win;
      if (q.cfg.rx_transparent) begin
        take = 1'b1;
        obit = win[0];
      end else if (win == hrx_pkg::FLAG_PATTERN) begin
        end_msg      = in_msg;
        next_q.rx_st = hrx_pkg::ST_FRAME;
        crc_clr      = 1'b1;
      end else if (win == hrx_pkg::ABORT_PATTERN) begin
        if (in_msg) begin
          ev_code = hrx_pkg::abort_seen_code;
          ev_irq  = !q.cfg.message_error_irq_mask;
          ev_ret  = 1'b1;
        end
        next_q.rx_st = hrx_pkg::ST_HUNT;
        crc_clr      = 1'b1;
      end else if (q.rx_st == hrx_pkg::ST_FRAME &&
                   q.raw[4:0] != hrx_pkg::STUFF_RUN) begin
        // Flag bits lag six places so they never reach the message
        next_q.dly = {q.dly[4:0], win[0]};
        if (q.dly_cnt == hrx_pkg::FLAG_LAG_BITS) begin
          take = 1'b1;
          obit = q.dly[5];
        end else begin
          next_q.dly_cnt = q.dly_cnt + 3'h1;
        end
      end
    end

    // Octet assembly and memory write
    if (take) begin
      next_q.asm_byte = {obit, q.asm_byte[7:1]};
      next_q.msg_bits = q.msg_bits + 1'b1;
      if (q.msg_bits[2:0] == 3'h7) begin
        if (!q.cfg.rx_transparent && q.msg_bits[MSG_W-1:3] >= lim) begin
          ev_code      = hrx_pkg::overlength_code;
          ev_irq       = !q.cfg.message_error_irq_mask;
          ev_ret       = 1'b1;
          ss7_oct      = 1'b1;
          next_q.rx_st = hrx_pkg::ST_HUNT;
          crc_clr      = 1'b1;
        end else begin
          next_q.mem_valid = desc_device_owned;
          next_q.mem_data  = {obit, q.asm_byte[7:1]};
        end
      end
    end

    // Closing flag verdict
    if (end_msg) begin
      if (q.msg_bits < MSG_W'(hrx_pkg::MIN_MSG_BITS)) begin
        ev_code = hrx_pkg::underlength_code;
        ev_irq  = !q.cfg.idle_class_irq_mask;
        ss7_inc = 1'b1;
      end else if (q.msg_bits[2:0] != 3'h0) begin
        ev_code = hrx_pkg::misalign_code;
        ev_irq  = !q.cfg.message_error_irq_mask;
        ev_ret  = 1'b1;
        ss7_oct = 1'b1;
      end else if (!crc_good) begin
        ev_code = hrx_pkg::crc_mismatch_code;
        ev_irq  = !q.cfg.message_error_irq_mask;
        ev_ret  = 1'b1;
        ss7_inc = 1'b1;
      end else begin
        ev_ret   = 1'b1;
        ss7_good = 1'b1;
      end
    end

    // Frame loss, taken in a cycle free of bit work
    next_q.los_pend = q.los_pend || los_rise;
    if (svc_los) begin
      next_q.los_pend = los_rise;
      ev_code         = hrx_pkg::frame_loss_code;
      ev_irq          = !q.cfg.frame_loss_irq_mask;
      if (q.cfg.frame_loss_abort_select && in_msg &&
          !q.cfg.rx_transparent) begin
        ev_ret       = 1'b1;
        next_q.rx_st = hrx_pkg::ST_HUNT;
        crc_clr      = 1'b1;
      end
    end

    if (crc_clr) begin
      next_q.msg_bits = '0;
      next_q.dly_cnt  = 3'h0;
    end

    // Descriptor hand back
    if (ev_ret) begin
      next_q.next_fetch  = 1'b1;
      next_q.stat.valid  = !q.cfg.rx_status_writeback_inhibit;
      next_q.stat.owner  = hrx_pkg::OWNER_HOST;
      next_q.stat.code   = ev_code;
    end

    // SS7 error rate counter
    if (in_ss7) begin
      if (ss7_oct) begin
        next_q.oct_errs = q.oct_errs + 1'b1;
        ss7_inc         = ss7_inc || (q.oct_errs == '1);
      end
      if (ss7_inc || ss7_oct) begin
        next_q.good_run = '0;
      end
      if (ss7_good) begin
        next_q.good_run = q.good_run + 1'b1;
        if (q.good_run == '1 && q.su_cnt != '0) begin
          next_q.su_cnt = q.su_cnt - 1'b1;
        end
      end
      if (ss7_inc) begin
        if (q.su_cnt != '1) begin
          next_q.su_cnt = q.su_cnt + 1'b1;
        end
        su_hit = (next_q.su_cnt >= q.cfg.signal_unit_error_threshold) &&
                 !q.cfg.signal_unit_error_irq_mask;
      end
    end

    // Transparent transmit ownership watch
    if (q.cfg.tx_transparent && q.tx_st == hrx_pkg::TX_ACTIVE &&
        tx_fifo_empty) begin
      if (tx_next_owned) begin
        next_q.tx_fetch = 1'b1;
      end else begin
        next_q.tx_st = hrx_pkg::TX_REPORT;
      end
    end

    // One interrupt descriptor per cycle
    if (ev_irq) begin
      next_q.irq       = '{valid: 1'b1, dir: hrx_pkg::DIR_RX, code: ev_code};
      next_q.last_code = ev_code;
    end else if (q.su_pend) begin
      next_q.su_pend   = 1'b0;
      next_q.irq       = '{valid: 1'b1, dir: hrx_pkg::DIR_RX,
                           code: hrx_pkg::signal_unit_error_rate_code};
      next_q.last_code = hrx_pkg::signal_unit_error_rate_code;
    end else if (q.tx_st == hrx_pkg::TX_REPORT) begin
      next_q.irq   = '{valid: 1'b1, dir: hrx_pkg::DIR_TX,
                       code: hrx_pkg::owner_error_code};
      next_q.tx_st = hrx_pkg::TX_DEACT;
    end
    next_q.su_pend = next_q.su_pend || su_hit;

    // Register access
    if (apb_setup) begin
      next_q.rdata = hit_cfg  ? 32'(q.cfg) :
                     hit_stat ? 32'(sreg)  : 32'h00000000;
    end
    if (apb_wr && hit_cfg) begin
      next_q.cfg      = hrx_pkg::hrx_cfg_s'(pwdata[hrx_pkg::CFG_W-1:0]);
      next_q.cfg.rsvd = '0;
    end
    if (apb_wr && hit_ctrl && pwdata[hrx_pkg::CTRL_REACTIVATE_BIT] &&
        q.tx_st == hrx_pkg::TX_DEACT) begin
      next_q.tx_st = hrx_pkg::TX_ACTIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.cfg   <= hrx_pkg::hrx_cfg_s'(hrx_pkg::CFG_RESET);
      q.rx_st <= hrx_pkg::ST_HUNT;
      q.tx_st <= hrx_pkg::TX_ACTIVE;
    end else if (ce) begin
      q <= next_q;
    end
  end

  hrx_crc16 u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (crc_clr),
    .bit_en  (take && !q.cfg.rx_transparent),
    .bit_in  (obit),
    .good    (crc_good)
  );

  assign prdata          = q.rdata;
  assign mem_byte_valid  = q.mem_valid;
  assign mem_byte        = q.mem_data;
  assign next_desc_fetch = q.next_fetch;
  assign status_desc     = q.stat;
  assign irq_desc        = q.irq;
  assign tx_desc_fetch   = q.tx_fetch;
  assign tx_idle_send    = (q.tx_st == hrx_pkg::TX_DEACT);
  assign tx_active       = (q.tx_st != hrx_pkg::TX_DEACT);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  frame_loss_irq_a: assert property (
    ce && svc_los && !q.cfg.frame_loss_irq_mask |=>
      irq_desc.valid && irq_desc.code == hrx_pkg::frame_loss_code)
    else $error("frame loss interrupt missing");

  frame_loss_mask_a: assert property (
    ce && svc_los && q.cfg.frame_loss_irq_mask |=> !irq_desc.valid)
    else $error("masked frame loss interrupt posted");

  loss_discard_a: assert property (
    ce && svc_los && q.cfg.frame_loss_abort_select && in_msg &&
    !q.cfg.rx_transparent |=>
      next_desc_fetch && q.rx_st == hrx_pkg::ST_HUNT)
    else $error("frame loss did not return descriptor");

  loss_continue_a: assert property (
    ce && svc_los && !q.cfg.frame_loss_abort_select |=>
      !next_desc_fetch && $stable(q.rx_st))
    else $error("frame loss disturbed reception");

  short_keep_a: assert property (
    irq_desc.valid && irq_desc.code == hrx_pkg::underlength_code |->
      !next_desc_fetch && !status_desc.valid)
    else $error("short message released descriptor");

  status_owner_a: assert property (
    status_desc.valid |->
      next_desc_fetch && status_desc.owner == hrx_pkg::OWNER_HOST)
    else $error("status written without host ownership");

  mem_owned_a: assert property (
    mem_byte_valid |-> $past(desc_device_owned))
    else $error("memory write to host-owned descriptor");

  tx_poll_a: assert property (
    tx_desc_fetch |-> $past(tx_next_owned) && $past(tx_fifo_empty))
    else $error("host-owned transmit descriptor polled");

  tx_order_a: assert property (
    $rose(tx_idle_send) |->
      irq_desc.valid && irq_desc.dir == hrx_pkg::DIR_TX &&
      irq_desc.code == hrx_pkg::owner_error_code)
    else $error("channel idled without ownership error");

  su_rate_a: assert property (
    irq_desc.valid &&
    irq_desc.code == hrx_pkg::signal_unit_error_rate_code |->
      $past(q.cfg.ss7_mode, 2) &&
      !$past(q.cfg.signal_unit_error_irq_mask, 2))
    else $error("rate interrupt outside enabled SS7 mode");

  crc_cover_c: cover property (
    irq_desc.valid && irq_desc.code == hrx_pkg::crc_mismatch_code);
  short_cover_c: cover property (
    irq_desc.valid && irq_desc.code == hrx_pkg::underlength_code);
  good_msg_c: cover property (
    status_desc.valid && status_desc.code == hrx_pkg::no_error_code);
  tx_deact_c: cover property ($rose(tx_idle_send));

endmodule
`default_nettype wire

/* File: dv/hrx_framer_model.sv */
`default_nettype none
module hrx_framer_model (
  // Link to receiver
  output logic link_clk,
  output logic link_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] crc;
  int          ones;
  initial begin
    link_clk = 1'b0;
    link_rxd = 1'b1;
  end
  // ======================
  // Bit level, clock idle between frames
  task automatic put(input logic b);
    link_rxd = b;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask
  task automatic flag();
    for (int k = 0; k < 8; k++) put(hrx_pkg::FLAG_PATTERN[k]);
    ones = 0;
  endtask
  // Data bit with CRC and zero stuffing
  task automatic dat(input logic b);
    crc = (crc >> 1) ^ ((crc[0] ^ b) ? 16'h8408 : 16'h0000);
    put(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      put(1'b0);
      ones = 0;
    end
  endtask
  // ======================
  // Mode 0 good, 1 bad FCS, 2 three extra bits, 3 abort
  task automatic frame(input int n, input int md);
    logic [15:0] fcs;
    logic [7:0]  d;
    crc = 16'hFFFF;
    flag();
    for (int i = 0; i < n; i++) begin
      d = 8'hA0 + 8'(i);
      for (int k = 0; k < 8; k++) dat(d[k]);
    end
    if (md == 2) repeat (3) dat(1'b0);
    if (md == 3) begin
      put(1'b0);
      repeat (7) put(1'b1);
    end else begin
      fcs = ~crc ^ ((md == 1) ? 16'h0001 : 16'h0000);
      for (int k = 0; k < 16; k++) dat(fcs[k]);
      flag();
    end
    link_rxd = ~link_rxd;
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [23:0] cfg; logic own; int n; int md; int nb;
    int nf; int ns; logic [3:0] sc; logic [31:0] irq;} hrx_row_s;
  logic               pclk, presetn, psel, penable, pwrite, e;
  logic               own, fl, txe, txo;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd, irq_set;
  logic               pready, pslverr, mem_byte_valid, next_desc_fetch;
  logic               tx_desc_fetch, tx_idle_send, tx_active;
  logic [7:0]         mem_byte, b0, b0e;
  hrx_pkg::hrx_stat_s status_desc;
  hrx_pkg::hrx_irq_s  irq_desc;
  wire logic          link_clk, link_rxd;
  int                 fail_count, compares, nb, nf, ns, ntx;
  logic [3:0]         sc;
  hrx_row_s rows[10] = '{
    '{24'h000100, 1'b1, 0, 0, 4, 0, 0, 4'h0, 32'h00000000},
    '{24'h000000, 1'b1, 4, 0, 6, 1, 1, 4'h0, 32'h00000000},
    '{24'h000000, 1'b1, 4, 1, 6, 1, 1, 4'h2, 32'h00000004},
    '{24'h000000, 1'b1, 4, 2, 6, 1, 1, 4'h3, 32'h00000008},
    '{24'h000000, 1'b1, 2, 3, 2, 1, 1, 4'h4, 32'h00000010},
    '{24'h000000, 1'b1, 0, 0, -1, 0, 0, 4'h0, 32'h00000040},
    '{24'h00000C, 1'b1, 4, 1, 6, 1, 0, 4'h0, 32'h00000000},
    '{24'h000000, 1'b0, 4, 0, 0, -1, -1, 4'h0, 32'h00000000},
    '{24'h000000, 1'b1, 257, 3, 256, 1, 1, 4'h5, 32'h00000020},
    '{24'h010400, 1'b1, 4, 1, 6, 1, 1, 4'h2, 32'h00000084}};
  hrx_channel hrx_channel_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_rxd(link_rxd), .link_frame_loss(fl),
    .desc_device_owned(own), .mem_byte_valid(mem_byte_valid),
    .mem_byte(mem_byte), .next_desc_fetch(next_desc_fetch),
    .status_desc(status_desc), .irq_desc(irq_desc), .tx_fifo_empty(txe),
    .tx_next_owned(txo), .tx_desc_fetch(tx_desc_fetch),
    .tx_idle_send(tx_idle_send), .tx_active(tx_active));
  hrx_framer_model hrx_framer_model_inst (.link_clk(link_clk),
    .link_rxd(link_rxd));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ======================
  // Monitor of the memory and interrupt side
  always @(posedge pclk) begin
    if (mem_byte_valid === 1'b1 && nb == 0) b0 = mem_byte;
    if (mem_byte_valid === 1'b1) nb++;
    if (next_desc_fetch === 1'b1) nf++;
    if (tx_desc_fetch === 1'b1) ntx++;
    if (status_desc.valid === 1'b1) begin
      ns++;
      sc = status_desc.code;
    end
    if (irq_desc.valid === 1'b1) irq_set[{irq_desc.dir, irq_desc.code}] = 1;
  end
  task automatic clr();
    @(negedge pclk);
    {nb, nf, ns, ntx} = '0;
    irq_set = 32'h00000000;
  endtask
  // ======================
  // APB master
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #900us;
    fail_count++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {own, fl, txe, txo, fail_count, compares} = '0;
    clr();
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("tx_active", 1'b1, tx_active)
    apb(1'b0, 12'h000, 32'h00000000);
    `CHK("cfg rst", 32'h00000000, rd)
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h00000000);
    `CHK("cfg rw", 32'h00FF07FF, rd)
    apb(1'b0, 12'h00C, 32'h00000000);
    `CHK("unmapped", 33'h000000001, {rd, e})
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {8'h00, rows[i].cfg});
      own <= rows[i].own;
      b0e = rows[i].cfg[8] ? hrx_pkg::FLAG_PATTERN : 8'hA0;
      clr();
      hrx_framer_model_inst.frame(rows[i].n, rows[i].md);
      repeat (60) @(posedge pclk);
      if (rows[i].nb >= 0) `CHK("bytes", rows[i].nb, nb)
      if (rows[i].nb > 0) `CHK("first", b0e, b0)
      if (rows[i].nf >= 0) `CHK("fetch", rows[i].nf, nf)
      if (rows[i].ns >= 0) `CHK("stat", rows[i].ns, ns)
      if (rows[i].ns > 0) `CHK("code", rows[i].sc, sc)
      `CHK("irq", rows[i].irq, irq_set)
    end
    // Frame loss, unmasked then masked
    apb(1'b1, 12'h000, 32'h00000000);
    clr();
    fl <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("oof irq", 32'h00000002, irq_set)
    fl <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000001);
    clr();
    fl <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("oof mask", 32'h00000000, irq_set)
    // Frame loss inside a message with abort select
    fl <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000002);
    clr();
    fork
      hrx_framer_model_inst.frame(8, 0);
      begin
        repeat (300) @(posedge pclk);
        fl <= 1'b1;
      end
    join
    repeat (60) @(posedge pclk);
    `CHK("oof bytes", 0, nb)
    `CHK("oof fetch", 1, nf)
    `CHK("oof stat", 1, ns)
    `CHK("oof code", 4'h1, sc)
    `CHK("oof irq2", 32'h00000002, irq_set)
    apb(1'b0, 12'h008, 32'h00000000);
    `CHK("rehunt", 1'b1, rd[0])
    fl <= 1'b0;
    // Transparent transmit ownership loss
    apb(1'b1, 12'h000, 32'h00000200);
    {txe, txo} <= 2'b11;
    clr();
    repeat (5) @(posedge pclk);
    `CHK("txfetch", 1'b1, ntx > 0)
    txo <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK("onr irq", 32'h01000000, irq_set)
    clr();
    repeat (10) @(posedge pclk);
    `CHK("no poll", 0, ntx)
    `CHK("idle", 2'b10, {tx_idle_send, tx_active})
    txe <= 1'b0;
    apb(1'b1, 12'h004, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK("react", 2'b01, {tx_idle_send, tx_active})
    // Reset in mid-run while the channel is idled
    {txe, txo} <= 2'b10;
    repeat (5) @(posedge pclk);
    `CHK("idle2", 2'b10, {tx_idle_send, tx_active})
    presetn <= 1'b0;
    {txe, txo} <= 2'b00;
    repeat (2) @(posedge pclk);
    `CHK("rst idle", 2'b01, {tx_idle_send, tx_active})
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h00000000);
    `CHK("cfg rst2", 32'h00000000, rd)
    test_done();
  end
endmodule
`default_nettype wire
